// [inc/mps_pkg.sv]
// constants and types for the master/slave phase synchroniser
// assumes a 40 MHz control clock and a shared link clock from the master
package mps_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int PW = 16;
  localparam int RMW = 4;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_MODE = 8'h00;
  localparam logic [AW-1:0] OFS_CMD = 8'h04;
  localparam logic [AW-1:0] OFS_PHASE = 8'h08;
  localparam logic [AW-1:0] OFS_FREQ = 8'h0c;
  localparam logic [AW-1:0] OFS_RUNMODE = 8'h10;
  localparam logic [AW-1:0] OFS_STATUS = 8'h14;
  // ----------------------------------------
  // field positions and codes
  // ----------------------------------------
  localparam int CMD_CONFIRM = 0;
  localparam int CMD_CANCEL = 1;
  localparam int CMD_SYNC = 2;
  localparam int ST_PEND = 2;
  localparam int ST_ARMED = 3;
  localparam int ST_LOCKED = 4;
  localparam logic [1:0] CM_OUTPUT = 2'h0;
  localparam logic [1:0] CM_INPUT = 2'h1;
  localparam logic [1:0] CM_PHASE_LOCK = 2'h2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [PW-1:0] PHASE_RST = 16'h0000;
  localparam logic [PW-1:0] FREQ_RST = 16'h0100;
  localparam logic [RMW-1:0] RUN_RST = 4'h0;
  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [3:0] {
    CK_OUT = 4'b0001,
    CK_IN = 4'b0010,
    CK_PEND = 4'b0100,
    CK_SLAVE = 4'b1000
  } mps_clk_t;
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_ARMED = 3'b010,
    LK_LOCKED = 3'b100
  } mps_lock_t;
endpackage

// [rtl/mps_sync2.sv]
// two-flop level synchroniser
// assumes d is a level from another domain or a pin
`timescale 1ns/1ps
module mps_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level
  input wire logic d,
  output logic q
);
  logic s1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      q <= s1;
    end
  end
endmodule

// [rtl/mps_link.sv]
// link-domain phase accumulator with trigger alignment
// assumes link_clk is the shared master clock; phase and freq are
// held stable while arm is high
`timescale 1ns/1ps
module mps_link
  import mps_pkg::*;
(
  // link clock and reset
  input wire logic link_clk,
  input wire logic rstn,
  // from control domain
  input wire logic arm,
  input wire logic [mps_pkg::PW-1:0] phase,
  input wire logic [mps_pkg::PW-1:0] freq,
  // pins
  input wire logic external_trigger_input,
  output logic wave_out,
  output logic sync_out,
  // handshake back
  output logic done
);
  logic arm_s;
  logic trig_s;
  logic trig_d;
  logic edge_t;
  logic [PW-1:0] acc;
  logic [PW-1:0] frq;
  logic [PW:0] sum;
  logic next_done;
  logic next_wave;
  logic next_sync;
  logic [PW-1:0] next_acc;
  logic [PW-1:0] next_frq;
  logic load;

  // ----------------------------------------
  // crossings
  // ----------------------------------------
  mps_sync2 u_arm (.clk(link_clk), .rstn(rstn), .d(arm), .q(arm_s));
  mps_sync2 u_trig (.clk(link_clk), .rstn(rstn), .d(external_trigger_input), .q(trig_s));

  assign edge_t = trig_s & ~trig_d;
  assign sum = {1'b0, acc} + {1'b0, frq};
  assign load = arm_s & edge_t & ~done;

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  always_comb begin
    next_acc = sum[PW-1:0];
    next_frq = frq;
    next_done = done;
    if (!arm_s) begin
      next_done = 1'b0;
    end else if (load) begin
      // negative phase loads a lagging start point
      next_acc = phase;
      next_frq = freq;
      next_done = 1'b1;
    end
    next_wave = next_acc[PW-1];
    next_sync = sum[PW] & ~load;
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      trig_d <= 1'b0;
      acc <= PHASE_RST;
      frq <= FREQ_RST;
      done <= 1'b0;
      wave_out <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      trig_d <= trig_s;
      acc <= next_acc;
      frq <= next_frq;
      done <= next_done;
      wave_out <= next_wave;
      sync_out <= next_sync;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_trig_load: assert property (@(posedge link_clk) disable iff (!rstn)
    load |=> acc == $past(phase) && done) else $error("trigger did not load phase");
  a_free_run: assert property (@(posedge link_clk) disable iff (!rstn)
    !load |=> acc == $past(acc) + $past(frq)) else $error("accumulator skipped");
  a_one_shot: assert property (@(posedge link_clk) disable iff (!rstn)
    done && arm_s |=> done && acc == $past(acc) + $past(frq))
    else $error("second load on one arm");
endmodule

// [rtl/mps_phase_sync.sv]
// master/slave phase synchroniser: clock socket mode, sync arming,
// lock tracking and register port
// assumes a 40 MHz clk; link_clk is the shared clock seen on the socket
//
// Functional notes
// - all units run from the master's socket clock as one time base.
// - an armed slave aligns to its programmed phase on the trigger.
// - negative phase delays the slave; -90 degrees lags a quarter period.
// - direct trigger references the master; chained sync outputs accumulate offsets.
// - master drives its clock out; slaves take phase-lock mode.
// - sync happens only on manual sync; lock then holds without pulses.
// - any slave reconfiguration rewrites waveform memory and drops the lock.
// - sync phase offset is never clamped by auxiliary-output limits.
// - phase-lock selection cancels run modes and needs explicit confirmation; here run_mode is cleared only on confirm, and cancel keeps it.
// - input mode uses the socket as external clock input, no drive.
`timescale 1ns/1ps
module mps_phase_sync
  import mps_pkg::*;
(
  // clocks and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic link_clk,
  // register port
  input wire logic [mps_pkg::AW-1:0] addr,
  input wire logic [mps_pkg::DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [mps_pkg::DW-1:0] rdata,
  // clock socket
  output logic sock_clk_o,
  output logic sock_clk_oe,
  // trigger and sync pins
  input wire logic external_trigger_input,
  output logic sync_out,
  // waveform side
  output logic wave_out,
  output logic wave_rewrite,
  output logic [mps_pkg::RMW-1:0] run_mode
);
  import mps_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  mps_clk_t ck;
  mps_clk_t next_ck;
  mps_lock_t lk;
  mps_lock_t next_lk;
  logic prev_in;
  logic next_prev_in;
  logic [PW-1:0] phase;
  logic [PW-1:0] next_phase;
  logic [PW-1:0] freq;
  logic [PW-1:0] next_freq;
  logic [PW-1:0] phx;
  logic [PW-1:0] next_phx;
  logic [PW-1:0] frx;
  logic [PW-1:0] next_frx;
  logic [RMW-1:0] next_run;
  logic arm;
  logic next_arm;
  logic next_rewrite;
  logic div;
  logic next_div;
  logic next_oe;
  logic [DW-1:0] next_rdata;
  logic done_l;
  logic done_s;
  logic wr_mode;
  logic wr_cmd;
  logic wr_phase;
  logic wr_freq;
  logic wr_run;
  logic sync_cmd;
  logic confirm;
  logic cancel;
  logic leave_slave;
  logic reconfig;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [1:0] mode_code(input mps_clk_t s, input logic pin);
    logic [1:0] c;
    c = CM_OUTPUT;
    if (s == CK_IN) begin
      c = CM_INPUT;
    end else if (s == CK_SLAVE) begin
      c = CM_PHASE_LOCK;
    end else if (s == CK_PEND) begin
      c = pin ? CM_INPUT : CM_OUTPUT;
    end
    mode_code = c;
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign wr_mode = wr & hit(addr, OFS_MODE);
  assign wr_cmd = wr & hit(addr, OFS_CMD);
  assign wr_phase = wr & hit(addr, OFS_PHASE);
  assign wr_freq = wr & hit(addr, OFS_FREQ);
  assign wr_run = wr & hit(addr, OFS_RUNMODE);
  assign confirm = wr_cmd & wdata[CMD_CONFIRM];
  assign cancel = wr_cmd & wdata[CMD_CANCEL];
  assign sync_cmd = wr_cmd & wdata[CMD_SYNC];
  assign leave_slave = wr_mode & (ck == CK_SLAVE) & (wdata[1:0] != CM_PHASE_LOCK);
  assign reconfig = wr_phase | wr_freq | wr_run | leave_slave;

  // ----------------------------------------
  // clock socket mode
  // ----------------------------------------
  always_comb begin
    next_ck = ck;
    next_prev_in = prev_in;
    next_run = run_mode;
    if (wr_mode) begin
      unique case (wdata[1:0])
        CM_OUTPUT: begin
          next_ck = CK_OUT;
          next_prev_in = 1'b0;
        end
        CM_INPUT: begin
          next_ck = CK_IN;
          next_prev_in = 1'b1;
        end
        CM_PHASE_LOCK: begin
          if (ck != CK_SLAVE) begin
            next_ck = CK_PEND;
          end
        end
        default: begin
          next_ck = ck;
        end
      endcase
    end else if ((ck == CK_PEND) && confirm) begin
      next_ck = CK_SLAVE;
      next_run = RUN_RST;
    end else if ((ck == CK_PEND) && cancel) begin
      next_ck = prev_in ? CK_IN : CK_OUT;
    end
    if (wr_run) begin
      next_run = wdata[RMW-1:0];
    end
  end

  // ----------------------------------------
  // configuration words and lock tracking
  // ----------------------------------------
  always_comb begin
    next_lk = lk;
    next_arm = arm;
    next_phx = phx;
    next_frx = frx;
    next_phase = phase;
    next_freq = freq;
    next_rewrite = 1'b0;
    if (wr_phase) begin
      next_phase = wdata[PW-1:0];
    end
    if (wr_freq) begin
      next_freq = wdata[PW-1:0];
    end
    unique case (lk)
      LK_IDLE, LK_LOCKED: begin
        if (sync_cmd && (ck == CK_SLAVE) && !done_s) begin
          next_lk = LK_ARMED;
          next_arm = 1'b1;
          next_phx = phase;
          next_frx = freq;
        end
      end
      LK_ARMED: begin
        if (done_s) begin
          next_lk = LK_LOCKED;
          next_arm = 1'b0;
        end
      end
    endcase
    if (reconfig) begin
      next_lk = LK_IDLE;
      next_arm = 1'b0;
      next_rewrite = 1'b1;
    end
  end

  // ----------------------------------------
  // clock drive and read port
  // ----------------------------------------
  always_comb begin
    next_div = ~div;
    next_oe = (next_ck == CK_OUT);
    next_rdata = '0;
    if (rd) begin
      unique case (addr)
        OFS_MODE: next_rdata[1:0] = mode_code(ck, prev_in);
        OFS_PHASE: next_rdata[PW-1:0] = phase;
        OFS_FREQ: next_rdata[PW-1:0] = freq;
        OFS_RUNMODE: next_rdata[RMW-1:0] = run_mode;
        OFS_STATUS: begin
          next_rdata[1:0] = mode_code(ck, prev_in);
          next_rdata[ST_PEND] = (ck == CK_PEND);
          next_rdata[ST_ARMED] = (lk == LK_ARMED);
          next_rdata[ST_LOCKED] = (lk == LK_LOCKED);
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ck <= CK_OUT;
      prev_in <= 1'b0;
      run_mode <= RUN_RST;
      lk <= LK_IDLE;
      arm <= 1'b0;
      phase <= PHASE_RST;
      freq <= FREQ_RST;
      phx <= PHASE_RST;
      frx <= FREQ_RST;
      wave_rewrite <= 1'b0;
      div <= 1'b0;
      sock_clk_oe <= 1'b1;
      rdata <= '0;
    end else begin
      ck <= next_ck;
      prev_in <= next_prev_in;
      run_mode <= next_run;
      lk <= next_lk;
      arm <= next_arm;
      phase <= next_phase;
      freq <= next_freq;
      phx <= next_phx;
      frx <= next_frx;
      wave_rewrite <= next_rewrite;
      div <= next_div;
      sock_clk_oe <= next_oe;
      rdata <= next_rdata;
    end
  end

  // master clock out is clk/2; gated off unless driving
  assign sock_clk_o = div & sock_clk_oe;

  // ----------------------------------------
  // link side
  // ----------------------------------------
  mps_link u_link (
    .link_clk(link_clk),
    .rstn(rstn),
    .arm(arm),
    .phase(phx),
    .freq(frx),
    .external_trigger_input(external_trigger_input),
    .wave_out(wave_out),
    .sync_out(sync_out),
    .done(done_l)
  );

  mps_sync2 u_done (.clk(clk), .rstn(rstn), .d(done_l), .q(done_s));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_confirm_slave: assert property (@(posedge clk) disable iff (!rstn)
    (ck == CK_PEND) && confirm && !wr_mode && !wr_run |=> ck == CK_SLAVE && run_mode == 4'h0)
    else $error("confirm did not enter slave mode");
  a_pend_waits: assert property (@(posedge clk) disable iff (!rstn)
    (ck == CK_PEND) && !confirm && !cancel && !wr_mode |=> ck == CK_PEND)
    else $error("pending mode left without confirm");
  a_output_drive: assert property (@(posedge clk) disable iff (!rstn)
    ck == CK_OUT |-> sock_clk_oe) else $error("master not driving clock");
  a_input_nodrive: assert property (@(posedge clk) disable iff (!rstn)
    (ck == CK_IN) || (ck == CK_SLAVE) |-> !sock_clk_oe && !sock_clk_o)
    else $error("socket driven in input mode");
  a_reconf_drop: assert property (@(posedge clk) disable iff (!rstn)
    reconfig |=> lk == LK_IDLE && !arm && wave_rewrite) else $error("lock kept after change");
  a_sync_refused: assert property (@(posedge clk) disable iff (!rstn)
    sync_cmd && (ck != CK_SLAVE) && (lk == LK_IDLE) |=> lk == LK_IDLE)
    else $error("armed outside slave mode");
  a_lock_holds: assert property (@(posedge clk) disable iff (!rstn)
    (lk == LK_LOCKED) && !reconfig && !sync_cmd |=> lk == LK_LOCKED)
    else $error("lock lost without change");
  a_phase_full: assert property (@(posedge clk) disable iff (!rstn)
    wr_phase |=> phase == $past(wdata[15:0])) else $error("phase value altered");
  a_arm_lock: assert property (@(posedge clk) disable iff (!rstn)
    (lk == LK_ARMED) && done_s && !reconfig |=> lk == LK_LOCKED && !arm)
    else $error("completed sync not recorded");
endmodule

// [tb/mps_master_model.sv]
// partner model: a master unit driving the shared clock and sync pulse
// assumes the slave takes link_clk on its socket and sync on its trigger
`timescale 1ns/1ps
module mps_master_model #(
  parameter logic [15:0] FREQ = 16'h0100
) (
  // shared clock
  output logic link_clk,
  // sync pulse
  output logic sync
);
  logic [15:0] acc;
  // ----------------------------------------
  // clock socket in output mode
  // ----------------------------------------
  initial begin
    link_clk = 1'b0;
    #3;
    forever begin
      link_clk = 1'b1;
      #40;
      link_clk = 1'b0;
      #40;
    end
  end
  // ----------------------------------------
  // accumulator, sync on wrap
  // ----------------------------------------
  initial begin
    acc = 16'h0000;
    sync = 1'b0;
  end
  always @(posedge link_clk) begin
    {sync, acc} <= {1'b0, acc} + {1'b0, FREQ}; // same freq, ratio 1:1
  end
endmodule

// [tb/mps_phase_sync_bench.sv]
// self-checking bench for the phase synchroniser
// assumes the master model supplies link_clk and the trigger pulse
`timescale 1ns/1ps
module mps_phase_sync_bench;
  import mps_pkg::*;
  logic clk, rstn, wr, rd, link_clk, m_sync, b;
  logic sock_clk_o, sock_clk_oe, sync_out, wave_out, wave_rewrite;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, v;
  logic [RMW-1:0] run_mode;
  logic [15:0] ph;
  int n_mismatch, check_count, seed, lag, i;
  // ----------------------------------------
  // design and partner
  // ----------------------------------------
  mps_phase_sync mps_phase_sync_i (.clk, .rstn, .link_clk, .addr, .wdata, .wr, .rd, .rdata,
    .sock_clk_o, .sock_clk_oe, .external_trigger_input(m_sync), .sync_out, .wave_out, .wave_rewrite,
    .run_mode);
  mps_master_model mps_master_model_i (.link_clk(link_clk), .sync(m_sync));
  always #12.5 clk = ~clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  function automatic int exp_lag(input logic [15:0] p);
    return (((32'h10000 - p) + 255) >> 8) & 255;
  endfunction
  task automatic measure(input logic [15:0] p);
    do begin
      @(posedge link_clk);
      #1;
    end while (m_sync !== 1'b1);
    lag = 0;
    do begin
      @(posedge link_clk);
      #1;
      lag++;
    end while (sync_out !== 1'b1 && lag < 600);
    check(sync_out, 1'b1);
    check(wave_out, 1'b0);
    check(((lag - exp_lag(p)) & 255) <= 6, 1'b1);
    repeat (128) @(posedge link_clk);
    #1;
    check(wave_out, 1'b1);
  endtask
  task automatic sync_run(input logic [15:0] p);
    wr_reg(OFS_PHASE, {16'h0000, p});
    check(wave_rewrite, 1'b1);
    rd_reg(OFS_STATUS);
    check(v[ST_LOCKED], 1'b0);
    repeat (20) @(posedge link_clk);
    wr_reg(OFS_CMD, 32'h4);
    rd_reg(OFS_STATUS);
    check(v[ST_ARMED] | v[ST_LOCKED], 1'b1);
    i = 0;
    do begin
      rd_reg(OFS_STATUS);
      i++;
    end while (v[ST_LOCKED] !== 1'b1 && i < 2000);
    check(v[ST_LOCKED], 1'b1);
    measure(p);
    repeat (600) @(posedge link_clk);
    rd_reg(OFS_STATUS);
    check(v[ST_LOCKED], 1'b1);
    measure(p);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    seed = 32'h8db6;
    n_mismatch = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(OFS_STATUS);
    check(v, 32'h0);
    check(sock_clk_oe, 1'b1);
    rd_reg(OFS_PHASE);
    check(v, {16'h0000, PHASE_RST});
    rd_reg(OFS_FREQ);
    check(v, {16'h0000, FREQ_RST});
    rd_reg(OFS_CMD);
    check(v, 32'h0);
    @(posedge clk);
    #1;
    b = sock_clk_o;
    @(posedge clk);
    #1;
    check(sock_clk_o, !b);
    wr_reg(8'h18, $random(seed));
    rd_reg(8'h18);
    check(v, 32'h0);
    wr_reg(OFS_MODE, 32'h3);
    wr_reg(OFS_CMD, 32'h4);
    rd_reg(OFS_STATUS);
    check(v[4:0], 5'h00);
    wr_reg(OFS_MODE, {30'h0, CM_INPUT});
    check(sock_clk_oe, 1'b0);
    rd_reg(OFS_STATUS);
    check(v[1:0], CM_INPUT);
    wr_reg(OFS_MODE, {30'h0, CM_OUTPUT});
    check(sock_clk_oe, 1'b1);
    ph = $random(seed);
    wr_reg(OFS_RUNMODE, {28'h0, ph[3:0] | 4'h1});
    wr_reg(OFS_MODE, {30'h0, CM_PHASE_LOCK});
    rd_reg(OFS_STATUS);
    check(v[ST_PEND], 1'b1);
    check(run_mode, ph[3:0] | 4'h1);
    wr_reg(OFS_CMD, 32'h2);
    rd_reg(OFS_STATUS);
    check(v[2:0], 3'h0);
    wr_reg(OFS_MODE, {30'h0, CM_PHASE_LOCK});
    wr_reg(OFS_CMD, 32'h1);
    check(run_mode, 4'h0);
    check(sock_clk_oe, 1'b0);
    rd_reg(OFS_STATUS);
    check(v[2:0], 3'h2);
    wr_reg(OFS_FREQ, 32'h0100);
    wr_reg(OFS_PHASE, 32'h4000);
    repeat (600) @(posedge link_clk);
    rd_reg(OFS_STATUS);
    check(v[ST_LOCKED], 1'b0);
    sync_run(16'hc000);
    sync_run(16'h8000);
    sync_run(16'h0000);
    for (int k = 0; k < 2; k++) begin
      ph = $random(seed);
      sync_run(ph);
    end
    // re-arm while locked, then leave slave mode
    wr_reg(OFS_CMD, 32'h4);
    rd_reg(OFS_STATUS);
    check(v[ST_ARMED], 1'b1);
    i = 0;
    do begin
      rd_reg(OFS_STATUS);
      i++;
    end while (v[ST_LOCKED] !== 1'b1 && i < 2000);
    check(v[ST_LOCKED], 1'b1);
    wr_reg(OFS_MODE, {30'h0, CM_INPUT});
    check(wave_rewrite, 1'b1);
    check(sock_clk_oe, 1'b0);
    rd_reg(OFS_STATUS);
    check(v[4:0], 5'h01);
    wr_reg(OFS_MODE, {30'h0, CM_PHASE_LOCK});
    wr_reg(OFS_CMD, 32'h2);
    rd_reg(OFS_STATUS);
    check(v[2:0], 3'h1);
    finish_test();
  end
endmodule
